//--- core/sbs_pkg.sv
// Package for the status byte summary block: bit positions, widths,
// reset values and the command codes of the command port.
// Assumes one 10 MHz clock shared with the command parser that drives the block.
package sbs_pkg;

	// ==========================================================
	// Widths
	localparam int SBS_DATA_W = 16;
	localparam int SBS_BYTE_W = 8;

	// ==========================================================
	// Status byte bit positions
	localparam int SBS_BIT_ERR = 2;
	localparam int SBS_BIT_QUES = 3;
	localparam int SBS_BIT_MSG = 4;
	localparam int SBS_BIT_EVT = 5;
	localparam int SBS_BIT_MASTER = 6;
	localparam int SBS_BIT_OPER = 7;

	// ==========================================================
	// Masks and reset values
	localparam logic [7:0] SBS_SRE_MASK = 8'hBF;
	localparam logic [7:0] SBS_STDEV_IMPL_MASK = 8'hFD;
	localparam logic [7:0] SBS_SRE_RST = 8'h00;
	localparam logic [7:0] SBS_ESE_RST = 8'h00;
	localparam logic [7:0] SBS_STDEV_RST = 8'h00;
	localparam logic [15:0] SBS_QUES_EN_RST = 16'h0000;
	localparam logic [15:0] SBS_OPER_EN_RST = 16'h0000;

	// ==========================================================
	// Commands taken on the command port
	typedef enum logic [3:0] {
		SBS_CMD_NONE,
		SBS_CMD_SRE_WRITE,
		SBS_CMD_SRE_QUERY,
		SBS_CMD_ESE_WRITE,
		SBS_CMD_ESE_QUERY,
		SBS_CMD_ESR_QUERY,
		SBS_CMD_BYTE_QUERY,
		SBS_CMD_SERIAL_POLL,
		SBS_CMD_QUES_EN_WRITE,
		SBS_CMD_OPER_EN_WRITE
	} sbs_cmd_t;

endpackage : sbs_pkg

//--- core/sbs_status_summary.sv
// Status byte summary: gathers queue flags and masked event summaries into
// the status byte, serves serial poll and status byte query, holds the
// service request, standard event and summary enable registers.
// Assumes every input comes from logic on clk (the command parser and the
// event sources); no pin reaches this module directly.
//
// How it works
// - Bit 2 follows error queue not empty
// - Bit 3 is masked questionable event OR
// - Bit 4 follows output queue not empty
// - Bit 5 set while any enabled standard event
// - Bit 6 master summary; request service absent
// - Bit 7 is masked operation event OR
// - Bits 0 and 1 always read zero
// - Status byte query alters no state
// - Serial poll and query both answered
// - Summary is OR of event AND enable
// - Only enable masks, no transition filters
// - Master summary ORs byte AND service enable
// - Reading standard event register clears it
// - Zero service enable blocks any request
`timescale 1ns/100ps

module sbs_status_summary
	import sbs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Status sources
	input wire logic err_queue_not_empty,
	input wire logic out_queue_not_empty,
	input wire logic [15:0] ques_event,
	input wire logic [15:0] oper_event,
	input wire logic [7:0] std_event_set,
	// Command port
	input wire logic cmd_valid,
	input wire sbs_cmd_t cmd_code,
	input wire logic [SBS_DATA_W-1:0] cmd_data,
	// Response port
	output logic resp_valid,
	output logic [SBS_DATA_W-1:0] resp_data,
	// Live status
	output logic [7:0] status_summary_byte,
	output logic master_summary,
	output logic questionable_summary,
	output logic operation_summary,
	output logic event_summary_flag,
	output logic message_available_flag
);

	// ==========================================================
	// Helpers

	// Summary of an event register through its enable mask
	function automatic logic sbs_masked_or(input logic [15:0] ev, input logic [15:0] en);
		return |(ev & en);
	endfunction : sbs_masked_or

	// ==========================================================
	// Registers

	logic [7:0] sre;
	logic [7:0] ese;
	logic [7:0] std_event;
	logic [15:0] ques_enable;
	logic [15:0] oper_enable;

	// ==========================================================
	// Command decode

	wire logic sre_wr = cmd_valid && (cmd_code == SBS_CMD_SRE_WRITE);
	wire logic ese_wr = cmd_valid && (cmd_code == SBS_CMD_ESE_WRITE);
	wire logic ques_en_wr = cmd_valid && (cmd_code == SBS_CMD_QUES_EN_WRITE);
	wire logic oper_en_wr = cmd_valid && (cmd_code == SBS_CMD_OPER_EN_WRITE);
	wire logic esr_rd = cmd_valid && (cmd_code == SBS_CMD_ESR_QUERY);
	wire logic byte_rd = cmd_valid && (cmd_code == SBS_CMD_BYTE_QUERY);
	wire logic poll_rd = cmd_valid && (cmd_code == SBS_CMD_SERIAL_POLL);
	wire logic ese_rd = cmd_valid && (cmd_code == SBS_CMD_ESE_QUERY);
	wire logic sre_rd = cmd_valid && (cmd_code == SBS_CMD_SRE_QUERY);
	wire logic any_query = esr_rd || byte_rd || poll_rd || ese_rd || sre_rd;

	// ==========================================================
	// Summary bits, formed combinationally from current state

	wire logic ques_sum_now = sbs_masked_or(ques_event, ques_enable);
	wire logic oper_sum_now = sbs_masked_or(oper_event, oper_enable);
	wire logic evt_sum_now = sbs_masked_or({8'h00, std_event}, {8'h00, ese});

	// Status byte without bit 6; reserved bits tied low
	wire logic [7:0] byte_core = {
		oper_sum_now,
		1'b0,
		evt_sum_now,
		out_queue_not_empty,
		ques_sum_now,
		err_queue_not_empty,
		2'b00
	};

	// Master summary: bit 6 excluded from the mask
	wire logic [7:0] sre_eff = sre & SBS_SRE_MASK;
	wire logic master_now = |(byte_core & sre_eff);

	// Byte as the query returns it and as the poll returns it
	wire logic [7:0] query_byte = byte_core | {1'b0, master_now, 6'h00};
	wire logic [7:0] poll_byte = byte_core;

	// Standard event register next value: a new event beats the read clear
	// so that an event landing in the cycle of the read is never lost
	wire logic [7:0] next_std_event = ((esr_rd ? SBS_STDEV_RST : std_event) | std_event_set)
		& SBS_STDEV_IMPL_MASK;

	// Response selection
	logic [SBS_DATA_W-1:0] next_resp_data;
	always_comb begin
		case (cmd_code)
			SBS_CMD_BYTE_QUERY: next_resp_data = {8'h00, query_byte};
			SBS_CMD_SERIAL_POLL: next_resp_data = {8'h00, poll_byte};
			SBS_CMD_ESR_QUERY: next_resp_data = {8'h00, std_event};
			SBS_CMD_ESE_QUERY: next_resp_data = {8'h00, ese};
			SBS_CMD_SRE_QUERY: next_resp_data = {8'h00, sre_eff};
			default: next_resp_data = 16'h0000;
		endcase
	end

	// ==========================================================
	// Enable registers, written by command

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sre <= SBS_SRE_RST;
			ese <= SBS_ESE_RST;
			ques_enable <= SBS_QUES_EN_RST;
			oper_enable <= SBS_OPER_EN_RST;
		end else begin
			if (sre_wr) begin
				sre <= cmd_data[7:0] & SBS_SRE_MASK;
			end
			if (ese_wr) begin
				ese <= cmd_data[7:0];
			end
			if (ques_en_wr) begin
				ques_enable <= cmd_data;
			end
			if (oper_en_wr) begin
				oper_enable <= cmd_data;
			end
		end
	end

	// Standard event register, cleared by its read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			std_event <= SBS_STDEV_RST;
		end else begin
			std_event <= next_std_event;
		end
	end

	// ==========================================================
	// Outputs from flip-flops

	// Live status refreshed every cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_summary_byte <= 8'h00;
			master_summary <= 1'b0;
			questionable_summary <= 1'b0;
			operation_summary <= 1'b0;
			event_summary_flag <= 1'b0;
			message_available_flag <= 1'b0;
		end else begin
			status_summary_byte <= query_byte;
			master_summary <= master_now;
			questionable_summary <= ques_sum_now;
			operation_summary <= oper_sum_now;
			event_summary_flag <= evt_sum_now;
			message_available_flag <= out_queue_not_empty;
		end
	end

	// Response one cycle after the query
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resp_valid <= 1'b0;
			resp_data <= 16'h0000;
		end else begin
			resp_valid <= any_query;
			if (any_query) begin
				resp_data <= next_resp_data;
			end
		end
	end

	// ==========================================================
	// Checks

	a_err_flag_tracks: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> status_summary_byte[SBS_BIT_ERR] == $past(err_queue_not_empty))
		else $error("error queue flag does not follow the queue");

	a_ques_summary_mask: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> questionable_summary == $past(|(ques_event & ques_enable)))
		else $error("questionable summary differs from masked events");

	a_ques_byte_bit: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> status_summary_byte[SBS_BIT_QUES] == $past(|(ques_event & ques_enable)))
		else $error("status byte bit 3 differs from masked events");

	a_msg_flag_clear: assert property (@(posedge clk) disable iff (!arst_n)
		!out_queue_not_empty |=> !status_summary_byte[SBS_BIT_MSG] && !message_available_flag)
		else $error("message available set with empty output queue");

	a_msg_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
		out_queue_not_empty |=> status_summary_byte[SBS_BIT_MSG] && message_available_flag)
		else $error("message available missing with data queued");

	a_evt_sum_follows: assert property (@(posedge clk) disable iff (!arst_n)
		(|(std_event & ese)) |=> status_summary_byte[SBS_BIT_EVT])
		else $error("event summary missing for enabled event");

	a_evt_flag_tracks: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> event_summary_flag == $past(|(std_event & ese)))
		else $error("event summary flag differs from masked events");

	a_query_carries_master: assert property (@(posedge clk) disable iff (!arst_n)
		byte_rd |=> resp_valid && (resp_data[SBS_BIT_MASTER] == $past(master_now)))
		else $error("query bit 6 is not the master summary");

	a_poll_no_request: assert property (@(posedge clk) disable iff (!arst_n)
		poll_rd |=> resp_valid && !resp_data[SBS_BIT_MASTER])
		else $error("serial poll shows a request service bit");

	a_sre_bit6_zero: assert property (@(posedge clk) disable iff (!arst_n)
		sre[SBS_BIT_MASTER] == 1'b0)
		else $error("service enable holds bit 6");

	a_byte_master_bit: assert property (@(posedge clk) disable iff (!arst_n)
		status_summary_byte[SBS_BIT_MASTER] == master_summary)
		else $error("status byte bit 6 differs from master summary");

	a_oper_sum_tracks: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> operation_summary == $past(|(oper_event & oper_enable)))
		else $error("operation summary differs from masked events");

	a_oper_byte_bit: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> status_summary_byte[SBS_BIT_OPER] == $past(|(oper_event & oper_enable)))
		else $error("status byte bit 7 differs from masked events");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
		status_summary_byte[1:0] == 2'b00 && (!resp_valid || resp_data[15:8] == 8'h00))
		else $error("reserved bits not zero");

	a_query_no_side: assert property (@(posedge clk) disable iff (!arst_n)
		(byte_rd && std_event_set == 8'h00) |=> std_event == $past(std_event) && sre == $past(sre))
		else $error("status byte query altered state");

	a_query_keeps_enables: assert property (@(posedge clk) disable iff (!arst_n)
		byte_rd |=> ese == $past(ese) && ques_enable == $past(ques_enable) && oper_enable == $past(oper_enable))
		else $error("status byte query altered an enable");

	a_query_byte_value: assert property (@(posedge clk) disable iff (!arst_n)
		byte_rd |=> resp_data[7:0] == $past(query_byte))
		else $error("status byte query answer differs from the byte");

	// Command answers and master summary
	a_poll_byte_value: assert property (@(posedge clk) disable iff (!arst_n)
		poll_rd |=> resp_data[7:0] == $past(byte_core))
		else $error("serial poll answer differs from the byte");

	a_write_no_answer: assert property (@(posedge clk) disable iff (!arst_n)
		(cmd_valid && !any_query) |=> !resp_valid)
		else $error("write command produced an answer");

	a_master_from_byte: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> master_summary == $past(|(byte_core & sre & SBS_SRE_MASK)))
		else $error("master summary is not masked status byte");

	// Standard event register, master summary under zero enable, live status byte
	a_esr_returns_old: assert property (@(posedge clk) disable iff (!arst_n)
		esr_rd |=> resp_data[7:0] == $past(std_event))
		else $error("event register read did not return its old value");

	a_std_bit1_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(std_event & ~SBS_STDEV_IMPL_MASK) == 8'h00)
		else $error("unimplemented event bit is set");

	a_esr_read_clears: assert property (@(posedge clk) disable iff (!arst_n)
		(esr_rd && std_event_set == 8'h00) |=> std_event == 8'h00 ##1 !event_summary_flag)
		else $error("reading the standard event register did not clear it");

	a_set_beats_clear: assert property (@(posedge clk) disable iff (!arst_n)
		(esr_rd && std_event_set[0]) |=> std_event[0])
		else $error("event lost in the cycle of its read clear");

	a_sre_zero_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		(sre == 8'h00) [*2] |-> !master_summary)
		else $error("master summary with zero service enable");

	a_live_byte: assert property (@(posedge clk) disable iff (!arst_n)
		1'b1 |=> status_summary_byte == $past(query_byte))
		else $error("live status byte lags its sources");

endmodule : sbs_status_summary

//--- tb/sbs_ctrl_model.sv
// Remote controller model: issues commands on the command port, collects answers.
// Assumes the block answers a query exactly one cycle after taking it.
`timescale 1ns/100ps
module sbs_ctrl_model
	import sbs_pkg::*;
(
	// Clock
	input wire logic clk,
	// Command side
	output logic cmd_valid,
	output sbs_cmd_t cmd_code,
	output logic [SBS_DATA_W-1:0] cmd_data,
	// Answer side
	input wire logic resp_valid,
	input wire logic [SBS_DATA_W-1:0] resp_data
);
	// ==========================================================
	// Idle data shows the inverse of the last value, never a stale copy
	initial begin
		cmd_valid = 1'b0;
		cmd_code = SBS_CMD_NONE;
		cmd_data = 16'hA5A5;
	end

	// One command, held for one taking edge; answer sampled one cycle later
	task automatic send(input sbs_cmd_t code, input logic [15:0] data, output logic [15:0] rdata,
		output logic got);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_data <= data;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= SBS_CMD_NONE;
		cmd_data <= ~data;
		@(posedge clk);
		got = resp_valid;
		rdata = resp_data;
	endtask : send
endmodule : sbs_ctrl_model

//--- tb/tb.sv
// Testbench for the status byte summary block, scenario tasks, self-checking.
// Assumes the controller model drives the command port.
`timescale 1ns/100ps
module tb;
	import sbs_pkg::*;
	logic clk, arst_n, err_queue_not_empty, out_queue_not_empty;
	logic [15:0] ques_event, oper_event, cmd_data, resp_data, rd;
	logic [7:0] std_event_set, status_summary_byte;
	logic cmd_valid, resp_valid, got;
	sbs_cmd_t cmd_code;
	logic master_summary, questionable_summary, operation_summary, event_summary_flag, message_available_flag;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;

	sbs_status_summary i_sbs_status_summary (.clk, .arst_n, .err_queue_not_empty, .out_queue_not_empty,
		.ques_event, .oper_event, .std_event_set, .cmd_valid, .cmd_code, .cmd_data, .resp_valid,
		.resp_data, .status_summary_byte, .master_summary, .questionable_summary, .operation_summary,
		.event_summary_flag, .message_available_flag);
	sbs_ctrl_model i_sbs_ctrl_model (.clk, .cmd_valid, .cmd_code, .cmd_data, .resp_valid, .resp_data);

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			complete_run();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask : settle
	task automatic cmd(input sbs_cmd_t code, input logic [15:0] data);
		i_sbs_ctrl_model.send(code, data, rd, got);
	endtask : cmd
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Scenarios
	task automatic t_queues();
		@(posedge clk);
		err_queue_not_empty <= 1'b1;
		settle();
		chk("status byte", 16'h0004, status_summary_byte);
		out_queue_not_empty <= 1'b1;
		settle();
		chk("status byte", 16'h0014, status_summary_byte);
		chk("mav", 16'h0001, message_available_flag);
		err_queue_not_empty <= 1'b0;
		out_queue_not_empty <= 1'b0;
		settle();
		chk("status byte", 16'h0000, status_summary_byte);
	endtask : t_queues
	task automatic t_masks();
		@(posedge clk);
		ques_event <= 16'h8001;
		oper_event <= 16'h0100;
		settle();
		chk("status byte", 16'h0000, status_summary_byte);
		cmd(SBS_CMD_QUES_EN_WRITE, 16'h8000);
		chk("write answer", 16'h0000, got);
		cmd(SBS_CMD_OPER_EN_WRITE, 16'h0200);
		settle();
		chk("status byte", 16'h0008, status_summary_byte);
		chk("ques", 16'h0001, questionable_summary);
		cmd(SBS_CMD_OPER_EN_WRITE, 16'h0100);
		cmd(SBS_CMD_QUES_EN_WRITE, 16'h0002);
		settle();
		chk("status byte", 16'h0080, status_summary_byte);
		chk("oper", 16'h0001, operation_summary);
		ques_event <= 16'h0000;
		oper_event <= 16'h0000;
		settle();
	endtask : t_masks
	task automatic t_event();
		cmd(SBS_CMD_ESE_WRITE, 16'h0010);
		cmd(SBS_CMD_ESE_QUERY, 16'h0000);
		chk("ese", 16'h0010, rd);
		std_event_set <= 8'h12;
		@(posedge clk);
		std_event_set <= 8'h00;
		settle();
		chk("status byte", 16'h0020, status_summary_byte);
		cmd(SBS_CMD_ESR_QUERY, 16'h0000);
		chk("esr", 16'h0010, rd);
		settle();
		chk("esb", 16'h0000, event_summary_flag);
		cmd(SBS_CMD_ESR_QUERY, 16'h0000);
		chk("esr", 16'h0000, rd);
	endtask : t_event
	task automatic t_master();
		err_queue_not_empty <= 1'b1;
		settle();
		chk("mss", 16'h0000, master_summary);
		cmd(SBS_CMD_SRE_WRITE, 16'h00FF);
		cmd(SBS_CMD_SRE_QUERY, 16'h0000);
		chk("sre", 16'h00BF, rd);
		settle();
		chk("mss", 16'h0001, master_summary);
		cmd(SBS_CMD_BYTE_QUERY, 16'h0000);
		chk("byte query", 16'h0044, rd);
		cmd(SBS_CMD_BYTE_QUERY, 16'h0000);
		chk("byte query", 16'h0044, rd);
		cmd(SBS_CMD_SERIAL_POLL, 16'h0000);
		chk("poll", 16'h0004, rd);
		chk("poll answer", 16'h0001, got);
		cmd(SBS_CMD_SRE_WRITE, 16'h0008);
		settle();
		chk("mss", 16'h0000, master_summary);
		err_queue_not_empty <= 1'b0;
	endtask : t_master

	// ==========================================================
	// Main sequence
	initial begin
		arst_n = 1'b0;
		err_queue_not_empty = 1'b0;
		out_queue_not_empty = 1'b0;
		ques_event = 16'h0000;
		oper_event = 16'h0000;
		std_event_set = 8'h00;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		chk("status byte", 16'h0000, status_summary_byte);
		t_queues();
		t_masks();
		t_event();
		t_master();
		complete_run();
	end
endmodule : tb
